// File: common/smspi_regs.svh
// Constants for the serial memory slave front end
`ifndef SMSPI_REGS_SVH
`define SMSPI_REGS_SVH

`define SMSPI_MEM_DEPTH 2048
`define SMSPI_ADDR_W 11
`define SMSPI_ADDR_IGNORED 5
`define SMSPI_OP_WREN 8'h06
`define SMSPI_OP_WRDI 8'h04
`define SMSPI_OP_RDSR 8'h05
`define SMSPI_OP_WRSR 8'h01
`define SMSPI_OP_READ 8'h03
`define SMSPI_OP_WRITE 8'h02
`define SMSPI_STAT_WPEN 7
`define SMSPI_STAT_BP1 3
`define SMSPI_STAT_BP0 2
`define SMSPI_STAT_WEL 1
`define SMSPI_STAT_WMASK 8'h8C
`define SMSPI_STAT_RESET 8'h00

`endif

// File: common/smspi_pkg.sv
// Types for the serial memory slave front end
package smspi_pkg;

    typedef enum logic [2:0] {
        SM_IDLE,
        SM_OPCODE,
        SM_ADDR,
        SM_DATA,
        SM_STATUS,
        SM_DISCARD
    } smspi_state_e;

    typedef struct packed {
        logic selN;
        logic sck;
        logic sdi;
        logic holdN;
        logic wpN;
    } smspi_pins_s;

    typedef struct packed {
        logic sdo;
        logic sdoEn;
    } smspi_out_s;

endpackage

// File: logic/smspi_front_end.sv
// Serial memory slave front end with 2048 by 8 array and status register
`timescale 1ns/10ps
`include "smspi_regs.svh"

module smspi_front_end (
    input wire logic clk,                   // System clock, 125 MHz
    input wire logic resetn,                // Asynchronous reset, active low
    input wire smspi_pkg::smspi_pins_s pins, // Select, clock, data, hold, protect
    output smspi_pkg::smspi_out_s link,     // Serial data out and its enable
    output logic [1:0] spiMode              // Mode picked at select: 0 or 3
);
    import smspi_pkg::*;

    // Pin synchroniser and edge history
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [4:0] prev;
    // Array and status register
    logic [7:0] mem [0:`SMSPI_MEM_DEPTH-1];
    logic [7:0] status;
    // Sequencer state
    smspi_state_e state;
    logic [7:0] shift;
    logic [2:0] bitCnt;
    logic addrByte;
    logic [`SMSPI_ADDR_W-1:0] addr;
    logic [7:0] opcode;
    logic [7:0] txByte;
    logic armed;
    logic wrDone;

    // Second stage only is read by logic
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync1 <= 5'h1F;
            sync2 <= 5'h1F;
        end else begin
            sync1 <= {pins.selN, pins.sck, pins.sdi, pins.holdN, pins.wpN};
            sync2 <= sync1;
        end
    end

    // One more stage of history for edge detection
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prev <= 5'h1F;
        end else begin
            prev <= sync2;
        end
    end

    wire selN = sync2[4];
    wire sckNow = sync2[3];
    wire sdi = sync2[2];
    wire holdN = sync2[1];
    wire wpN = sync2[0];
    wire selPrevN = prev[4];
    wire sckPrev = prev[3];
    wire holdPrevN = prev[1];

    // Hold freezes clock and select transitions
    wire active = holdN && holdPrevN;
    wire selFall = active && selPrevN && !selN;
    wire selRise = active && !selPrevN && selN;
    wire sckRise = active && !selN && !sckPrev && sckNow && armed;
    wire sckFall = active && !selN && sckPrev && !sckNow;
    wire [7:0] nextShift = {shift[6:0], sdi};
    wire takeBit = sckRise && (state != SM_IDLE) && (state != SM_DISCARD);
    wire byteDone = takeBit && (bitCnt == 3'h7);
    wire [1:0] modeAtSelect = sckNow ? 2'h3 : 2'h0;
    wire armNow = active && !selN && !sckNow;

    // Only the six command codes are accepted
    function automatic logic opValid(input logic [7:0] op);
        unique case (op)
            `SMSPI_OP_WREN,
            `SMSPI_OP_WRDI,
            `SMSPI_OP_RDSR,
            `SMSPI_OP_WRSR,
            `SMSPI_OP_READ,
            `SMSPI_OP_WRITE: opValid = 1'b1;
            default: opValid = 1'b0;
        endcase
    endfunction

    function automatic logic blockProt(input logic [1:0] bp,
                                       input logic [`SMSPI_ADDR_W-1:0] a);
        unique case (bp)
            2'h0: blockProt = 1'b0;
            2'h1: blockProt = (a[10:9] == 2'h3);
            2'h2: blockProt = a[10];
            2'h3: blockProt = 1'b1;
        endcase
    endfunction

    // Phase that follows a complete opcode byte
    function automatic smspi_state_e opRoute(input logic [7:0] op);
        if (!opValid(op)) begin
            opRoute = SM_DISCARD;
        end else if (op == `SMSPI_OP_READ || op == `SMSPI_OP_WRITE) begin
            opRoute = SM_ADDR;
        end else if (op == `SMSPI_OP_RDSR || op == `SMSPI_OP_WRSR) begin
            opRoute = SM_STATUS;
        end else begin
            opRoute = SM_DISCARD;
        end
    endfunction

    wire wel = status[`SMSPI_STAT_WEL];
    wire [1:0] bp = {status[`SMSPI_STAT_BP1], status[`SMSPI_STAT_BP0]};
    wire statusLocked = status[`SMSPI_STAT_WPEN] && !wpN;
    wire memWrite = (state == SM_DATA) && byteDone && (opcode == `SMSPI_OP_WRITE) &&
                    wel && !blockProt(bp, addr);
    wire statWrite = (state == SM_STATUS) && byteDone &&
                     (opcode == `SMSPI_OP_WRSR) && wel && !statusLocked;
    wire isRead = (opcode == `SMSPI_OP_READ) || (opcode == `SMSPI_OP_RDSR);
    wire [7:0] statusRead = status & (`SMSPI_STAT_WMASK | 8'h02);
    wire [`SMSPI_ADDR_W-1:0] nextAddr = addr + 11'h001;
    wire [`SMSPI_ADDR_W-1:0] loadAddr = {addr[2:0], nextShift};
    wire driving = !selN && holdN && (state == SM_DATA || state == SM_STATUS) &&
                   isRead;

    // Byte boundary strobes split by phase, plus the per-bit output shift strobe
    wire opDone = byteDone && (state == SM_OPCODE);
    wire statRead = opDone && (nextShift == `SMSPI_OP_RDSR);
    wire addrLoad = byteDone && (state == SM_ADDR);
    wire addrDone = addrLoad && addrByte;
    wire dataDone = byteDone && (state == SM_DATA);
    wire shiftOut = sckFall && driving;
    wire welSet = opDone && (nextShift == `SMSPI_OP_WREN);
    // Latch clear waits for deselect after a write command
    wire welClear = selRise && wrDone;
    wire deselect = selRise || (active && selN);

    // Mode 3 arms only after the clock has gone low
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            armed <= 1'b0;
        end else if (selFall) begin
            armed <= !sckNow;
        end else if (armNow) begin
            armed <= 1'b1;
        end else if (selRise) begin
            armed <= 1'b0;
        end
    end

    // Mode is fixed for the whole selection
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            spiMode <= 2'h0;
        end else if (selFall) begin
            spiMode <= modeAtSelect;
        end
    end

    // Shift register cleared at every selection
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shift <= 8'h00;
        end else if (selFall) begin
            shift <= 8'h00;
        end else if (takeBit) begin
            shift <= nextShift;
        end
    end

    // Bit counter; a byte cut by deselect is dropped
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bitCnt <= 3'h0;
        end else if (selFall) begin
            bitCnt <= 3'h0;
        end else if (deselect) begin
            bitCnt <= 3'h0;
        end else if (takeBit) begin
            bitCnt <= bitCnt + 3'h1;
        end
    end

    // Byte address: built from both address bytes, then stepped per data byte
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            addr <= '0;
        end else if (addrLoad) begin
            addr <= loadAddr;
        end else if (dataDone) begin
            addr <= nextAddr;
        end
    end

    // Protocol sequencer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= SM_IDLE;
            addrByte <= 1'b0;
            opcode <= 8'h00;
            wrDone <= 1'b0;
        end else if (selFall) begin
            state <= SM_OPCODE;
            addrByte <= 1'b0;
            wrDone <= 1'b0;
        end else if (deselect) begin
            state <= SM_IDLE;
        end else if (byteDone) begin
            unique case (state)
                // Opcode byte picks the phase; write disable clears at deselect
                SM_OPCODE: begin
                    opcode <= nextShift;
                    state <= opRoute(nextShift);
                    wrDone <= (nextShift == `SMSPI_OP_WRDI);
                end
                // Two address bytes, the second starts the data phase
                SM_ADDR: begin
                    addrByte <= 1'b1;
                    if (addrByte) begin
                        state <= SM_DATA;
                    end
                end
                // Data bytes run on until deselect
                SM_DATA: begin
                    wrDone <= wrDone | (opcode == `SMSPI_OP_WRITE);
                end
                // Exactly one status byte, then nothing more is taken
                SM_STATUS: begin
                    state <= SM_DISCARD;
                    wrDone <= (opcode == `SMSPI_OP_WRSR);
                end
                default: state <= SM_DISCARD;
            endcase
        end
    end

    // Array write completes on the byte's last edge
    always_ff @(posedge clk) begin
        if (memWrite) begin
            mem[addr] <= nextShift;
        end
    end

    // Status register; latch clears at deselect after a write command
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status <= `SMSPI_STAT_RESET;
        end else if (statWrite) begin
            status <= (nextShift & `SMSPI_STAT_WMASK) | (status & 8'h02);
        end else if (welSet) begin
            status[`SMSPI_STAT_WEL] <= 1'b1;
        end else if (welClear) begin
            status[`SMSPI_STAT_WEL] <= 1'b0;
        end
    end

    // Read byte loaded after an RDSR opcode, the second address byte and each data byte, then shifted on falling edges
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            txByte <= 8'h00;
        end else if (statRead) begin
            txByte <= statusRead;
        end else if (addrDone) begin
            txByte <= mem[loadAddr];
        end else if (dataDone) begin
            txByte <= mem[nextAddr];
        end else if (shiftOut) begin
            txByte <= {txByte[6:0], 1'b0};
        end
    end

    // Output bit moves only on a falling clock; enable drops when the read ends
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            link <= '0;
        end else begin
            if (shiftOut) begin
                link.sdo <= txByte[7];
            end
            if (!driving) begin
                link.sdoEn <= 1'b0;
            end else if (sckFall) begin
                link.sdoEn <= 1'b1;
            end
        end
    end

endmodule

// File: sim/smspi_monitor.sv
// Concurrent checks on the pins of the serial memory front end
`timescale 1ns/10ps
module smspi_monitor (
    input wire logic clk, // System clock
    input wire logic resetn, // Reset, active low
    input wire smspi_pkg::smspi_pins_s pins, // Master pins
    input wire smspi_pkg::smspi_out_s link, // Serial output
    input wire logic [1:0] spiMode // Mode at select
);
    import smspi_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    AST_DESEL_OFF: assert property (pins.selN [*6] |-> !link.sdoEn) else $error("sdo on");
    AST_HOLD_OFF: assert property (!pins.holdN [*6] |-> !link.sdoEn) else $error("held");
    AST_MODE_OK: assert property (spiMode == 2'd0 || spiMode == 2'd3) else $error("mode");
    AST_MODE_HELD: assert property (!pins.selN [*8] |-> $stable(spiMode)) else $error("moved");
    AST_MODE3: assert property ($fell(pins.selN) && pins.sck |-> ##[2:6] spiMode == 2'd3)
        else $error("mode 3");
    AST_MODE0: assert property ($fell(pins.selN) && !pins.sck |-> ##[2:6] spiMode == 2'd0)
        else $error("mode 0");
    AST_SCK_HIGH: assert property ((pins.sck && !pins.selN) [*4] |-> $stable(link.sdo))
        else $error("sdo moved");
    AST_EN_RISE: assert property ($rose(link.sdoEn) |-> !pins.selN && !pins.sck)
        else $error("early drive");
    cover property ($fell(pins.selN) && pins.sck);
    cover property ($rose(link.sdoEn));
    cover property (!pins.holdN && !pins.selN);
endmodule
bind smspi_front_end smspi_monitor u_mon (.clk(clk), .resetn(resetn), .pins(pins), .link(link),
    .spiMode(spiMode));

// File: sim/smspi_master.sv
// Serial bus master model for the memory front end
`timescale 1ns/10ps
module smspi_master (
    input wire logic clk, // System clock
    output smspi_pkg::smspi_pins_s pins, // Pins to device
    input wire smspi_pkg::smspi_out_s link // Device output
);
    import smspi_pkg::*;
    logic miso = 1'b0;
    logic idle = 1'b0;
    int enCount = 0;
    initial pins = 5'h13; // Hold starts high, protect tied high
    // A released line shows the inverse of its last level
    always @(posedge clk) miso <= link.sdoEn ? link.sdo : ~miso;
    always @(posedge clk) enCount <= enCount + int'(link.sdoEn);
    task automatic half();
        repeat (5) @(posedge clk);
    endtask
    task automatic sel(input logic m3);
        idle = m3;
        pins.sck <= m3;
        half();
        pins.selN <= 1'b0;
        half();
    endtask
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            pins.sck <= 1'b0;
            pins.sdi <= tx[i];
            half();
            pins.sck <= 1'b1;
            half();
            rx[i] = miso;
        end
    endtask
    task automatic desel();
        pins.sck <= idle;
        half();
        pins.selN <= 1'b1;
        half();
    endtask
    task automatic hold();
        pins.sck <= 1'b0;
        half();
        pins.holdN <= 1'b0;
        repeat (10) @(posedge clk);
        pins.holdN <= 1'b1;
    endtask
endmodule

// File: sim/test_serial_memory_spi_slave_front_end.sv
// Self-checking bench for the serial memory front end
`timescale 1ns/10ps
`include "smspi_regs.svh"
module test_serial_memory_spi_slave_front_end;
    import smspi_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    smspi_pins_s pins;
    smspi_out_s link;
    logic [1:0] spiMode;
    int miscompares = 0;
    int checks = 0;
    int n0;
    logic [7:0] rx;
    logic [7:0] wd;
    logic [10:0] a;
    always #4 clk = ~clk;
    smspi_front_end DUT (.clk(clk), .resetn(resetn), .pins(pins), .link(link), .spiMode(spiMode));
    smspi_master M (.clk(clk), .pins(pins), .link(link));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        if (miscompares == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Status with the protection bits clear
    function automatic logic [7:0] stat(input logic wel);
        return {6'h00, wel, 1'b0};
    endfunction
    task automatic go(input logic m3, input logic [7:0] op, input logic [15:0] adr);
        M.sel(m3);
        M.xfer(op, rx);
        M.xfer(adr[15:8], rx);
        M.xfer(adr[7:0], rx);
    endtask
    task automatic rdsr(input logic [7:0] exp);
        M.sel(1'b0);
        M.xfer(`SMSPI_OP_RDSR, rx);
        M.xfer(8'h00, rx);
        M.desel();
        check("status", rx, exp);
    endtask
    task automatic cmd(input logic [7:0] op);
        M.sel(1'b0);
        M.xfer(op, rx);
        M.desel();
    endtask
    initial begin
        void'($urandom(32));
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        for (int k = 0; k < 4; k++) begin
            a = (k == 0) ? 11'h7ff : 11'($urandom());
            wd = 8'($urandom());
            M.sel(k[0]);
            M.xfer(`SMSPI_OP_WREN, rx);
            M.desel();
            rdsr(stat(1'b1));
            go(k[0], `SMSPI_OP_WRITE, {5'h00, a});
            M.xfer(wd, rx);
            M.xfer(~wd, rx);
            M.desel();
            rdsr(stat(1'b0));
            go(~k[0], `SMSPI_OP_READ, {5'($urandom()), a});
            check("mode", {6'h00, spiMode}, {8{~k[0]}} & 8'h03);
            M.xfer(8'h00, rx);
            check("data", rx, wd);
            M.xfer(8'h00, rx);
            check("next", rx, ~wd);
            M.desel();
        end
        cmd(`SMSPI_OP_WREN);
        cmd(`SMSPI_OP_WRDI);
        rdsr(stat(1'b0));
        cmd(`SMSPI_OP_WREN);
        M.sel(1'b0);
        M.xfer(`SMSPI_OP_WRSR, rx);
        M.xfer(8'hff, rx);
        M.desel();
        rdsr(`SMSPI_STAT_WMASK);
        cmd(`SMSPI_OP_WREN);
        go(1'b0, `SMSPI_OP_WRITE, {5'h00, a});
        M.xfer(~wd, rx);
        M.desel();
        go(1'b1, `SMSPI_OP_READ, {5'h00, a});
        M.xfer(8'h00, rx);
        M.desel();
        check("protected", rx, wd);
        n0 = M.enCount;
        go(1'b0, 8'hff, {`SMSPI_OP_READ, 8'h00});
        M.xfer(8'h00, rx);
        M.xfer(8'h00, rx);
        M.desel();
        check("refused", 8'(M.enCount - n0), 8'h00);
        go(1'b1, `SMSPI_OP_READ, {5'h00, a});
        M.hold();
        M.desel();
        close_out();
    end
    initial begin
        #400000;
        miscompares++;
        close_out();
    end
endmodule
